// ---- bus_master.sv ----
`timescale 1ns/1ps
module bus_master #(
	parameter int TIMEOUT = bus_master_pkg::TIMEOUT_CYC
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic i_req,
	input wire bus_master_pkg::cmd_t i_cmd,
	output logic o_busy,
	output logic o_done,
	output bus_master_pkg::result_t o_result,
	output logic [31:0] o_rdata,
	output bus_master_pkg::pins_t o_pins,
	output logic o_ctl_oe,
	output logic o_adr_oe,
	output logic [31:0] o_data,
	output logic o_data_oe,
	input wire logic [31:0] i_data,
	input wire logic i_dtack_b,
	input wire logic i_berr_b,
	input wire logic i_retry_b
);
	typedef struct packed {
		bus_master_pkg::state_t st;
		logic [15:0] cnt;
		logic rmw;
		logic phase2;
		logic [31:0] wdata;
		bus_master_pkg::pins_t pins;
		logic ctl_oe;
		logic adr_oe;
		logic [31:0] data;
		logic data_oe;
		logic busy;
		logic done;
		bus_master_pkg::result_t result;
		logic [31:0] rdata;
	} regs_t;

	localparam logic [15:0] TO_CYC = 16'(TIMEOUT);

	regs_t r;
	regs_t next_r;
	logic [2:0] resp_b;
	logic [31:0] data_s;
	logic dtack_lo;
	logic berr_lo;
	logic retry_lo;

	pin_sync #(.W(3), .RST(bus_master_pkg::SYNC_RST)) u_resp_sync (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_d({i_retry_b, i_berr_b, i_dtack_b}),
		.o_q(resp_b)
	);

	// data lines settle before acknowledge, so they agree by the time it lands
	pin_sync #(.W(32), .RST(32'h0)) u_data_sync (
		.i_clk(i_clk),
		.i_rst_b(i_rst_b),
		.i_d(i_data),
		.o_q(data_s)
	);

	assign dtack_lo = !resp_b[0];
	assign berr_lo = !resp_b[1];
	assign retry_lo = !resp_b[2];

	always_comb
	begin
		next_r = r;
		next_r.done = 1'b0;
		if (r.cnt != 16'h0)
		begin
			next_r.cnt = r.cnt - 16'h1;
		end
		case (r.st)
			bus_master_pkg::S_IDLE:
			begin
				if (i_req)
				begin
					next_r.busy = 1'b1;
					next_r.rmw = i_cmd.rmw;
					next_r.phase2 = 1'b0;
					next_r.wdata = i_cmd.wdata;
					next_r.pins.write_b = !(i_cmd.write && !i_cmd.rmw);
					next_r.pins.iack_b = !i_cmd.iack;
					next_r.pins.lword_b = !i_cmd.lword;
					next_r.pins.am = i_cmd.am;
					next_r.pins.addr = i_cmd.addr;
					next_r.ctl_oe = 1'b1;
					next_r.adr_oe = 1'b1;
					next_r.data = i_cmd.wdata;
					next_r.data_oe = i_cmd.write && !i_cmd.rmw;
					next_r.cnt = bus_master_pkg::ADDR_SETUP_CYC;
					next_r.st = bus_master_pkg::S_SETUP;
				end
			end
			bus_master_pkg::S_SETUP:
			begin
				if (r.cnt == 16'h0)
				begin
					next_r.pins.as_b = 1'b0;
					next_r.cnt = bus_master_pkg::AS_TO_DS_CYC;
					next_r.st = bus_master_pkg::S_DSWAIT;
				end
			end
			bus_master_pkg::S_DSWAIT:
			begin
				if (r.cnt == 16'h0)
				begin
					next_r.pins.ds0_b = 1'b0;
					next_r.pins.ds1_b = 1'b0;
					next_r.cnt = TO_CYC;
					next_r.st = bus_master_pkg::S_RESP;
				end
			end
			bus_master_pkg::S_RESP:
			begin
				// strobes and write data stay put until a response or the TO_CYC time-out
				if (dtack_lo || berr_lo)
				begin
					if (r.pins.write_b && dtack_lo)
					begin
						next_r.rdata = data_s;
					end
					next_r.result = berr_lo ? bus_master_pkg::RES_BUSERR
						: bus_master_pkg::RES_OK;
					next_r.pins.ds0_b = 1'b1;
					next_r.pins.ds1_b = 1'b1;
					next_r.st = bus_master_pkg::S_DSHIGH;
				end
				else if (retry_lo)
				begin
					// answering retry at once; a slow master would force
					next_r.result = bus_master_pkg::RES_RETRY;
					next_r.pins.ds0_b = 1'b1;
					next_r.pins.ds1_b = 1'b1;
					next_r.st = bus_master_pkg::S_RETRY;
				end
				else if (r.cnt == 16'h0)
				begin
					// no bus timer answered: abandon rather than hang
					next_r.result = bus_master_pkg::RES_TIMEOUT;
					next_r.pins.ds0_b = 1'b1;
					next_r.pins.ds1_b = 1'b1;
					next_r.st = bus_master_pkg::S_DSHIGH;
				end
			end
			bus_master_pkg::S_DSHIGH:
			begin
				// direction, modifiers and address strobe wait for the slave
				if (!dtack_lo && !berr_lo)
				begin
					if (r.rmw && !r.phase2 && r.result == bus_master_pkg::RES_OK)
					begin
						// address stays driven into the write half
						next_r.phase2 = 1'b1;
						next_r.pins.write_b = 1'b0;
						next_r.data = r.wdata;
						next_r.data_oe = 1'b1;
						next_r.cnt = bus_master_pkg::DS_GAP_CYC;
						next_r.st = bus_master_pkg::S_DSWAIT;
					end
					else
					begin
						next_r.pins.as_b = 1'b1;
						next_r.data_oe = 1'b0;
						next_r.adr_oe = 1'b0;
						next_r.cnt = bus_master_pkg::AS_HIGH_CYC;
						next_r.st = bus_master_pkg::S_RELEASE;
					end
				end
			end
			bus_master_pkg::S_RETRY:
			begin
				// strobe, modifiers and address held until retry rises
				if (!retry_lo)
				begin
					next_r.pins.as_b = 1'b1;
					next_r.data_oe = 1'b0;
					next_r.adr_oe = 1'b0;
					next_r.cnt = bus_master_pkg::AS_HIGH_CYC;
					next_r.st = bus_master_pkg::S_RELEASE;
				end
			end
			bus_master_pkg::S_RELEASE:
			begin
				if (r.cnt == 16'h0)
				begin
					next_r.ctl_oe = 1'b0;
					next_r.pins = bus_master_pkg::PINS_IDLE;
					next_r.busy = 1'b0;
					next_r.done = 1'b1;
					next_r.st = bus_master_pkg::S_IDLE;
				end
			end
			default:
			begin
				next_r.st = bus_master_pkg::S_IDLE;
			end
		endcase
	end

	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			r <= '{
				st: bus_master_pkg::S_IDLE, cnt: 16'h0, rmw: 1'b0, phase2: 1'b0,
				wdata: 32'h0, pins: bus_master_pkg::PINS_IDLE, ctl_oe: 1'b0,
				adr_oe: 1'b0, data: 32'h0, data_oe: 1'b0, busy: 1'b0, done: 1'b0,
				result: bus_master_pkg::RES_OK, rdata: 32'h0
			};
		end
		else
		begin
			r <= next_r;
		end
	end

	assign o_busy = r.busy;
	assign o_done = r.done;
	assign o_result = r.result;
	assign o_rdata = r.rdata;
	assign o_pins = r.pins;
	assign o_ctl_oe = r.ctl_oe;
	assign o_adr_oe = r.adr_oe;
	assign o_data = r.data;
	assign o_data_oe = r.data_oe;
endmodule : bus_master

// ---- bus_master_pkg.sv ----
package bus_master_pkg;

	localparam int CLK_MHZ = 50;

	// bus-side times; the handshake itself has no clock
	localparam int T_ADDR_SETUP_NS = 40;
	localparam int T_AS_TO_DS_NS = 20;
	localparam int T_DS_GAP_NS = 40;
	localparam int T_AS_HIGH_NS = 40;
	localparam int T_TIMEOUT_NS = 64000;

	function automatic logic [15:0] ns_to_cycles(input int ns);
		int c;
		c = (ns * CLK_MHZ + 999) / 1000;
		if (c < 1)
		begin
			c = 1;
		end
		return c[15:0];
	endfunction : ns_to_cycles

	localparam logic [15:0] ADDR_SETUP_CYC = ns_to_cycles(T_ADDR_SETUP_NS);
	localparam logic [15:0] AS_TO_DS_CYC = ns_to_cycles(T_AS_TO_DS_NS);
	localparam logic [15:0] DS_GAP_CYC = ns_to_cycles(T_DS_GAP_NS);
	localparam logic [15:0] AS_HIGH_CYC = ns_to_cycles(T_AS_HIGH_NS);
	localparam int TIMEOUT_CYC = (T_TIMEOUT_NS * CLK_MHZ + 999) / 1000;

	localparam logic [2:0] SYNC_RST = 3'h7;

	typedef enum logic [2:0] {
		S_IDLE = 3'h0,
		S_SETUP = 3'h1,
		S_DSWAIT = 3'h3,
		S_RESP = 3'h2,
		S_DSHIGH = 3'h6,
		S_RETRY = 3'h7,
		S_RELEASE = 3'h4
	} state_t;

	typedef enum logic [1:0] {
		RES_OK = 2'h0,
		RES_BUSERR = 2'h1,
		RES_RETRY = 2'h2,
		RES_TIMEOUT = 2'h3
	} result_t;

	typedef struct packed {
		logic write;
		logic rmw;
		logic iack;
		logic [5:0] am;
		logic [31:1] addr;
		logic lword;
		logic [31:0] wdata;
	} cmd_t;

	typedef struct packed {
		logic as_b;
		logic ds0_b;
		logic ds1_b;
		logic write_b;
		logic iack_b;
		logic lword_b;
		logic [5:0] am;
		logic [31:1] addr;
	} pins_t;

	localparam pins_t PINS_IDLE = '{
		as_b: 1'b1, ds0_b: 1'b1, ds1_b: 1'b1, write_b: 1'b1,
		iack_b: 1'b1, lword_b: 1'b1, am: 6'h00, addr: 31'h0
	};

endpackage : bus_master_pkg

// ---- pin_sync.sv ----
`timescale 1ns/1ps
module pin_sync #(
	parameter int W = 1,
	parameter logic [W-1:0] RST = '0
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire logic [W-1:0] i_d,
	output logic [W-1:0] o_q
);
	logic [W-1:0] s1;
	logic [W-1:0] s2;
	logic [W-1:0] s3;

	// s1 feeds only s2; a change is taken once s2 and s3 agree
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
		begin
			s1 <= RST;
			s2 <= RST;
			s3 <= RST;
			o_q <= RST;
		end
		else
		begin
			s1 <= i_d;
			s2 <= s1;
			s3 <= s2;
			for (int i = 0; i < W; i++)
			begin
				if (s2[i] == s3[i])
				begin
					o_q[i] <= s3[i];
				end
			end
		end
	end
endmodule : pin_sync

// ---- bus_master_monitor.sv ----
`timescale 1ns/1ps
module bus_master_monitor #(
	parameter int TIMEOUT = bus_master_pkg::TIMEOUT_CYC
) (
	input wire logic i_clk,
	input wire logic i_rst_b,
	input wire bus_master_pkg::pins_t o_pins,
	input wire logic o_data_oe,
	input wire logic [31:0] o_data,
	input wire logic i_dtack_b,
	input wire logic i_berr_b,
	input wire logic i_retry_b
);
	logic [15:0] ds_cnt;
	logic live;
	default clocking cb @(posedge i_clk);
	endclocking
	default disable iff (!i_rst_b);
	// hold duties lapse once the strobe has been low for half the local give-up time
	assign live = ds_cnt < 16'(TIMEOUT / 2);
	always_ff @(posedge i_clk or negedge i_rst_b)
	begin
		if (!i_rst_b)
			ds_cnt <= 16'h0;
		else
			ds_cnt <= o_pins.ds0_b ? 16'h0 : ds_cnt + 16'h1;
	end
	ds_hold_a:
		assert property (!o_pins.ds0_b && i_dtack_b && i_berr_b && i_retry_b && live
			|=> !o_pins.ds0_b) else $error("strobe rose with no response");
	ds_pair_a:
		assert property (o_pins.ds0_b == o_pins.ds1_b) else $error("strobes split");
	strobe_up_a:
		assert property ($fell(i_dtack_b) && !o_pins.ds0_b |-> ##[2:5] o_pins.ds0_b)
		else $error("strobe not raised after acknowledge");
	dir_hold_a:
		assert property (!o_pins.ds0_b || !o_pins.ds1_b |=> $stable(o_pins.write_b))
		else $error("direction moved under strobe");
	as_hold_a:
		assert property (!o_pins.as_b && live && (!o_pins.ds0_b || !i_dtack_b || !i_berr_b)
			|=> !o_pins.as_b) else $error("address strobe rose early");
	adr_hold_a:
		assert property (!o_pins.as_b |=> o_pins.as_b
			|| $stable({o_pins.iack_b, o_pins.am, o_pins.addr, o_pins.lword_b}))
		else $error("addressing moved under address strobe");
	retry_hold_a:
		assert property (!o_pins.as_b && !i_retry_b |=> !o_pins.as_b)
		else $error("address strobe rose during retry");
	wdata_hold_a:
		assert property (o_data_oe && !o_pins.write_b && !o_pins.ds0_b && i_dtack_b && i_berr_b
			|=> o_data_oe && $stable(o_data)) else $error("write data moved");
	read_free_a:
		assert property (o_pins.write_b && !o_pins.ds0_b |-> !o_data_oe)
		else $error("master drove data in a read");
	cover property ($fell(i_dtack_b) && !o_pins.write_b);
	cover property ($fell(i_berr_b));
	cover property ($fell(i_retry_b));
endmodule : bus_master_monitor
bind bus_master bus_master_monitor #(.TIMEOUT(TIMEOUT)) mon (.i_clk(i_clk),
	.i_rst_b(i_rst_b), .o_pins(o_pins), .o_data_oe(o_data_oe), .o_data(o_data),
	.i_dtack_b(i_dtack_b), .i_berr_b(i_berr_b), .i_retry_b(i_retry_b));

// ---- bus_slave_model.sv ----
`timescale 1ns/1ps
module bus_slave_model (
	input wire logic i_clk,
	input wire bus_master_pkg::pins_t i_pins,
	input wire logic [1:0] i_mode,
	input wire logic [7:0] i_wait,
	input wire logic [31:0] i_bus,
	output logic o_dtack_b,
	output logic o_berr_b,
	output logic o_retry_b,
	output logic o_drive,
	output logic [31:0] o_wseen
);
	logic [7:0] cnt;
	initial
	begin
		{o_dtack_b, o_berr_b, o_retry_b, o_drive} = 4'he;
		cnt = 8'h0;
		o_wseen = 32'h0;
	end
	// mode 0 acknowledge, 1 bus error, 2 retry, 3 silent so the master gives up
	always @(posedge i_clk)
	begin
		if (i_pins.ds0_b && i_pins.ds1_b)
		begin
			cnt <= 8'h0;
			o_drive <= 1'b0;
			if (!o_drive)
				{o_dtack_b, o_berr_b, o_retry_b} <= 3'h7;
		end
		else if (!i_pins.ds0_b && cnt != 8'hff)
		begin
			cnt <= cnt + 8'h1;
			if (cnt == i_wait && i_pins.write_b && i_mode == 2'h0)
				o_drive <= 1'b1;
			if (cnt == i_wait + 8'h1)
			begin
				o_wseen <= i_bus;
				o_dtack_b <= i_mode != 2'h0;
				o_berr_b <= i_mode != 2'h1;
				o_retry_b <= i_mode != 2'h2;
			end
		end
	end
endmodule : bus_slave_model

// ---- test_bus_master.sv ----
`timescale 1ns/1ps
`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
	$display("[FAIL] %0t got %h exp %h", $time, (a), (b)); end end
module test_bus_master;
	logic i_clk, i_rst_b, i_req, o_busy, o_done, o_ctl_oe, o_adr_oe, o_data_oe;
	logic dtack_b, berr_b, retry_b, drive;
	logic [1:0] mode;
	logic [7:0] wt;
	logic [31:0] o_rdata, o_data, rdata, wseen, pat;
	wire logic [31:0] bus;
	bus_master_pkg::cmd_t cmd;
	bus_master_pkg::result_t res;
	bus_master_pkg::pins_t pins;
	int n_fail, total_checks;
	// a released bus shows a changing pattern so stale data cannot pass
	assign bus = o_data_oe ? o_data : drive ? rdata : pat;
	bus_master #(.TIMEOUT(50)) uut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_req(i_req),
		.i_cmd(cmd), .o_busy(o_busy), .o_done(o_done), .o_result(res), .o_rdata(o_rdata),
		.o_pins(pins), .o_ctl_oe(o_ctl_oe), .o_adr_oe(o_adr_oe), .o_data(o_data),
		.o_data_oe(o_data_oe), .i_data(bus), .i_dtack_b(dtack_b), .i_berr_b(berr_b),
		.i_retry_b(retry_b));
	bus_slave_model slave (.i_clk(i_clk), .i_pins(pins), .i_mode(mode), .i_wait(wt),
		.i_bus(bus), .o_dtack_b(dtack_b), .o_berr_b(berr_b), .o_retry_b(retry_b),
		.o_drive(drive), .o_wseen(wseen));
	always @(posedge i_clk)
		pat <= ~pat;
	task automatic end_of_test();
		$display("checks %0d fails %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : end_of_test
	task automatic cycle(input logic wr, input logic rmw, input logic [1:0] md, input logic [7:0] w);
		int n;
		@(negedge i_clk);
		mode = md;
		wt = w;
		cmd = '{write: wr, rmw: rmw, iack: md[1], am: 6'h0d, addr: 31'h0abc_0124, lword: wr,
			wdata: ~rdata};
		i_req = 1'b1;
		@(negedge i_clk);
		i_req = 1'b0;
		`CHK({o_busy, o_ctl_oe, o_adr_oe, pins.as_b, pins.ds0_b, pins.ds1_b}, 6'h3f)
		`CHK({pins.write_b, pins.am}, {!(wr && !rmw), 6'h0d})
		`CHK({pins.iack_b, pins.lword_b, pins.addr}, {!md[1], !wr, 31'h0abc_0124})
		n = 0;
		while (o_done !== 1'b1 && n < 300)
		begin
			@(negedge i_clk);
			n++;
		end
		if (o_done !== 1'b1)
		begin
			n_fail++;
			end_of_test();
		end
		`CHK({pins, o_ctl_oe, o_adr_oe, o_data_oe}, {bus_master_pkg::PINS_IDLE, 3'h0})
		`CHK(o_busy, 1'b0)
	endtask : cycle
	task automatic t_read();
		rdata = 32'h1357_9bdf;
		cycle(1'b0, 1'b0, 2'h0, 8'h1);
		`CHK(res, bus_master_pkg::RES_OK)
		`CHK(o_rdata, rdata)
		$display("read test done");
	endtask : t_read
	task automatic t_write();
		rdata = 32'h0f1e_2d3c;
		cycle(1'b1, 1'b0, 2'h0, 8'h3);
		`CHK(res, bus_master_pkg::RES_OK)
		`CHK(wseen, ~rdata)
		$display("write test done");
	endtask : t_write
	task automatic t_berr();
		cycle(1'b0, 1'b0, 2'h1, 8'h2);
		`CHK(res, bus_master_pkg::RES_BUSERR)
		$display("bus error test done");
	endtask : t_berr
	task automatic t_retry();
		cycle(1'b1, 1'b0, 2'h2, 8'h1);
		`CHK(res, bus_master_pkg::RES_RETRY)
		$display("retry test done");
	endtask : t_retry
	task automatic t_timeout();
		cycle(1'b0, 1'b0, 2'h3, 8'h1);
		`CHK(res, bus_master_pkg::RES_TIMEOUT)
		$display("time-out test done");
	endtask : t_timeout
	task automatic t_rmw();
		rdata = 32'h8421_c3a5;
		cycle(1'b0, 1'b1, 2'h0, 8'h14);
		`CHK(res, bus_master_pkg::RES_OK)
		`CHK(o_rdata, rdata)
		`CHK(wseen, ~rdata)
		$display("read-modify-write test done");
	endtask : t_rmw
	initial
	begin
		i_clk = 1'b0;
		forever #10 i_clk = ~i_clk;
	end
	initial
	begin
		i_rst_b = 1'b0;
		i_req = 1'b0;
		cmd = '0;
		mode = 2'h0;
		wt = 8'h1;
		rdata = 32'h0;
		pat = 32'h5a5a_a5a5;
		n_fail = 0;
		total_checks = 0;
		repeat (12) @(negedge i_clk);
		i_rst_b = 1'b1;
		t_read();
		t_write();
		t_berr();
		t_retry();
		t_timeout();
		t_rmw();
		end_of_test();
	end
endmodule : test_bus_master
